// >>> src/bra_pkg.sv
package bra_pkg;

   // ==========================================================
   // Sizes
   // ==========================================================
   localparam int NUM_APP = 8;
   localparam int IDX_W = 3;

   // ==========================================================
   // Types
   // ==========================================================
   // Reservation states, binary coded.
   typedef enum logic [1:0] {
      ST_IDLE     = 2'h0,
      ST_WAIT_ACK = 2'h1,
      ST_GRANTED  = 2'h2,
      ST_REMOTE   = 2'h3
   } bra_state_t;

   // Remote bay word from the remote bay input chain.
   typedef struct packed {
      logic all_ack;
      logic remote_request_flag;
      logic remote_request_valid;
   } bra_remote_t;

   // Word passed between chained arbiters.
   typedef struct packed {
      logic reserved;
   } bra_chain_t;

   // Complete state of the arbiter.
   typedef struct packed {
      bra_state_t state;
      logic [IDX_W-1:0] idx;
      logic [NUM_APP-1:0] grant;
      logic req_other;
      logic ack;
      logic reserved;
   } bra_regs_t;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [IDX_W-1:0] IDX_RESET = 3'h0;
   localparam logic [NUM_APP-1:0] GRANT_RESET = 8'h00;
   localparam bra_regs_t REGS_RESET = '{
      state: ST_IDLE,
      idx: IDX_RESET,
      grant: GRANT_RESET,
      req_other: 1'h0,
      ack: 1'h0,
      reserved: 1'h0
   };
   localparam bra_chain_t CHAIN_RESET = '{reserved: 1'h0};

endpackage : bra_pkg

// >>> src/bra_prio_enc.sv
// Finds the lowest-indexed active request.
module bra_prio_enc (
   input wire logic [bra_pkg::NUM_APP-1:0] req_in,
   output logic any_out,
   output logic [bra_pkg::IDX_W-1:0] idx_out
);
   import bra_pkg::*;

   logic [NUM_APP-1:0] lower_busy;
   logic [NUM_APP-1:0] first;

   // ==========================================================
   // Lowest index wins
   // ==========================================================
   // Each bit is first only when no lower bit is requesting.
   assign lower_busy[0] = 1'h0;
   for (genvar i = 0; i < NUM_APP; i++) begin : g_bit
      if (i > 0) begin : g_chain
         assign lower_busy[i] = lower_busy[i-1] | req_in[i-1];
      end
      assign first[i] = req_in[i] & ~lower_busy[i];
   end

   // Encode the single first bit into an index.
   always_comb begin
      idx_out = IDX_RESET;
      for (int k = 0; k < NUM_APP; k++) begin
         if (first[k]) begin
            idx_out = IDX_W'(k);
         end
      end
   end

   assign any_out = |req_in;

endmodule : bra_prio_enc

// >>> src/bra_grant_dec.sv
// Turns a granted index into one grant line per apparatus.
module bra_grant_dec (
   input wire logic en_in,
   input wire logic [bra_pkg::IDX_W-1:0] idx_in,
   output logic [bra_pkg::NUM_APP-1:0] grant_out
);
   import bra_pkg::*;

   // ==========================================================
   // One-hot decode
   // ==========================================================
   // Only the addressed line can be high, so grants stay exclusive.
   for (genvar i = 0; i < NUM_APP; i++) begin : g_line
      assign grant_out[i] = en_in & (idx_in == IDX_W'(i));
   end

endmodule : bra_grant_dec

// >>> src/bra_arbiter.sv
// Bay reservation arbiter: one apparatus of the bay at a time, or the
// whole bay on behalf of another bay.
module bra_arbiter (
   input wire logic REF_CLK_IN,
   input wire logic RST_IN,
   input wire logic [bra_pkg::NUM_APP-1:0] APP_REQ_IN,
   input wire logic [bra_pkg::NUM_APP-1:0] OWN_BAY_ONLY_IN,
   input wire logic RES_BLOCK_IN,
   input wire logic OVERRIDE_IN,
   input wire bra_pkg::bra_remote_t REMOTE_INFO_IN,
   input wire bra_pkg::bra_chain_t CHAIN_LINK_IN,
   output logic [bra_pkg::NUM_APP-1:0] APP_GRANT_OUT,
   output logic REQ_OTHER_BAYS_OUT,
   output logic ACK_TO_OTHER_BAY_OUT,
   output logic RESERVED_OUT,
   output bra_pkg::bra_chain_t CHAIN_LINK_OUT
);
   import bra_pkg::*;

   bra_regs_t st_reg;
   bra_regs_t st_next;
   bra_chain_t chain_reg;
   bra_chain_t chain_next;
   logic any_req;
   logic [IDX_W-1:0] low_idx;
   logic [NUM_APP-1:0] grant_dec;
   logic remote_req;
   logic busy;
   logic held_req;

   // ==========================================================
   // Request selection
   // ==========================================================
   // Every apparatus drives its own line; the lowest one is picked.
   bra_prio_enc u_prio (
      .req_in(APP_REQ_IN),
      .any_out(any_req),
      .idx_out(low_idx)
   );

   // Grant lines for the index that the next state will hold.
   bra_grant_dec u_dec (
      .en_in(st_next.state == ST_GRANTED),
      .idx_in(st_next.idx),
      .grant_out(grant_dec)
   );

   // Remote request counts only when its validity flag is set.
   assign remote_req = REMOTE_INFO_IN.remote_request_flag &
                       REMOTE_INFO_IN.remote_request_valid;

   // A bay held by the first chained instance is busy for this one.
   assign busy = st_reg.reserved | CHAIN_LINK_IN.reserved;

   // Request of the apparatus that owns the reservation.
   assign held_req = APP_REQ_IN[st_reg.idx];

   // ==========================================================
   // Next state
   // ==========================================================
   // All decisions are made here; outputs are registered copies.
   always_comb begin
      st_next = st_reg;
      chain_next = chain_reg;
      unique case (st_reg.state)
         ST_IDLE: begin
            if (!busy && any_req) begin
               st_next.idx = low_idx;
               if (OWN_BAY_ONLY_IN[low_idx] || OVERRIDE_IN) begin
                  st_next.state = ST_GRANTED;
               end else begin
                  st_next.state = ST_WAIT_ACK;
               end
            end else if (!busy && remote_req) begin
               st_next.state = ST_REMOTE;
            end
         end
         ST_WAIT_ACK: begin
            if (!held_req) begin
               st_next.state = ST_IDLE;
            end else if (REMOTE_INFO_IN.all_ack || OVERRIDE_IN) begin
               st_next.state = ST_GRANTED;
            end
         end
         ST_GRANTED: begin
            if (!held_req) begin
               st_next.state = ST_IDLE;
            end
         end
         ST_REMOTE: begin
            if (!remote_req) begin
               st_next.state = ST_IDLE;
            end
         end
      endcase
      // The block input refuses and clears everything.
      if (RES_BLOCK_IN) begin
         st_next.state = ST_IDLE;
      end
      // Registered outputs follow the next state. A grant already held
      // keeps its other-bay request, so a later change of the override
      // input cannot raise it in the middle of an override reservation.
      st_next.grant = grant_dec;
      if ((st_reg.state == ST_GRANTED) && (st_next.state == ST_GRANTED)) begin
         st_next.req_other = st_reg.req_other;
      end else begin
         st_next.req_other = (st_next.state == ST_WAIT_ACK) ||
            ((st_next.state == ST_GRANTED) &&
             !OWN_BAY_ONLY_IN[st_next.idx] && !OVERRIDE_IN);
      end
      st_next.ack = (st_next.state == ST_REMOTE);
      st_next.reserved = (st_next.state != ST_IDLE);
      chain_next.reserved = st_next.reserved |
         (CHAIN_LINK_IN.reserved & ~RES_BLOCK_IN);
   end

   // ==========================================================
   // State register
   // ==========================================================
   // One register for the whole state and one for the chain output.
   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         st_reg <= REGS_RESET;
         chain_reg <= CHAIN_RESET;
      end else begin
         st_reg <= st_next;
         chain_reg <= chain_next;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   // All outputs come straight from flip-flops.
   assign APP_GRANT_OUT = st_reg.grant;
   assign REQ_OTHER_BAYS_OUT = st_reg.req_other;
   assign ACK_TO_OTHER_BAY_OUT = st_reg.ack;
   assign RESERVED_OUT = st_reg.reserved;
   assign CHAIN_LINK_OUT = chain_reg;

   // ==========================================================
   // Assertions
   // ==========================================================
   // Free bay seen by this instance, used by several properties.
   logic free_now;
   assign free_now = (st_reg.state == ST_IDLE) && !CHAIN_LINK_IN.reserved &&
                     !RES_BLOCK_IN;

   // Blocking clears every output at the next edge.
   property p_block_clear;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      RES_BLOCK_IN |=> (APP_GRANT_OUT == GRANT_RESET) &&
         !REQ_OTHER_BAYS_OUT && !ACK_TO_OTHER_BAY_OUT && !RESERVED_OUT;
   endproperty
   a_block_clear: assert property (p_block_clear)
      else $error("Outputs not cleared after block.");

   // Blocked bay accepts nothing for as long as the block lasts.
   property p_block_refuse;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      RES_BLOCK_IN [*2] |-> !RESERVED_OUT;
   endproperty
   a_block_refuse: assert property (p_block_refuse)
      else $error("Reservation made while blocked.");

   // At most one grant, and only while reserved.
   property p_one_grant;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      $onehot0(APP_GRANT_OUT) && ((APP_GRANT_OUT != 0) -> RESERVED_OUT);
   endproperty
   a_one_grant: assert property (p_one_grant)
      else $error("More than one grant or grant without reservation.");

   // A held grant is not moved to another requester.
   property p_no_second;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      (st_reg.state == ST_GRANTED) && held_req && !RES_BLOCK_IN
      |=> $stable(APP_GRANT_OUT);
   endproperty
   a_no_second: assert property (p_no_second)
      else $error("Grant changed while reserved.");

   // Own-bay-only request on a free bay is granted to its own line.
   property p_own_grant;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      free_now && $onehot(APP_REQ_IN) && ((APP_REQ_IN & OWN_BAY_ONLY_IN) != 0)
      |=> (APP_GRANT_OUT == $past(APP_REQ_IN)) && !REQ_OTHER_BAYS_OUT;
   endproperty
   a_own_grant: assert property (p_own_grant)
      else $error("Own-bay-only request not granted.");

   // Own-bay-only apparatuses never raise the other-bay request.
   property p_own_only;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      (OWN_BAY_ONLY_IN == 8'hFF) [*2] |-> !REQ_OTHER_BAYS_OUT;
   endproperty
   a_own_only: assert property (p_own_only)
      else $error("Other-bay request for own-bay-only apparatus.");

   // Other-bay request waits for acknowledge before any grant.
   property p_wait;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      free_now && (APP_REQ_IN != 0) && !OWN_BAY_ONLY_IN[low_idx] &&
      !OVERRIDE_IN |=> REQ_OTHER_BAYS_OUT && (APP_GRANT_OUT == GRANT_RESET);
   endproperty
   a_wait: assert property (p_wait)
      else $error("Other bays not requested or grant given early.");

   // Acknowledge from all bays grants the waiting apparatus.
   property p_ack_grant;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      (st_reg.state == ST_WAIT_ACK) && REMOTE_INFO_IN.all_ack && held_req &&
      !RES_BLOCK_IN |=> APP_GRANT_OUT[$past(st_reg.idx)];
   endproperty
   a_ack_grant: assert property (p_ack_grant)
      else $error("Acknowledge did not give the grant.");

   // Override grants at once.
   property p_override;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      free_now && any_req && OVERRIDE_IN |=> (APP_GRANT_OUT != 0);
   endproperty
   a_override: assert property (p_override)
      else $error("Override did not grant immediately.");

   // Free bay acknowledges a lone remote request and is reserved.
   property p_remote_ack;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      free_now && !any_req && remote_req
      |=> ACK_TO_OTHER_BAY_OUT && RESERVED_OUT;
   endproperty
   a_remote_ack: assert property (p_remote_ack)
      else $error("Remote request on free bay not acknowledged.");

   // Reserved bay gives no acknowledge to a new remote request.
   property p_remote_busy;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      RESERVED_OUT && !ACK_TO_OTHER_BAY_OUT && remote_req
      |=> !ACK_TO_OTHER_BAY_OUT;
   endproperty
   a_remote_busy: assert property (p_remote_busy)
      else $error("Acknowledge given while already reserved.");

   // Dropping the request frees the grant at the next edge.
   property p_release;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      (APP_GRANT_OUT != 0) && ((APP_GRANT_OUT & APP_REQ_IN) == 0)
      |=> (APP_GRANT_OUT == GRANT_RESET) && !RESERVED_OUT;
   endproperty
   a_release: assert property (p_release)
      else $error("Grant not released after request dropped.");

   // A held grant keeps its other-bay request unchanged.
   property p_req_steady;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      (st_reg.state == ST_GRANTED) && held_req && !RES_BLOCK_IN
      |=> $stable(REQ_OTHER_BAYS_OUT);
   endproperty
   a_req_steady: assert property (p_req_steady)
      else $error("Other-bay request changed during a grant.");

   // Waiting apparatus gets no grant before all bays acknowledge.
   property p_no_early;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      (st_reg.state == ST_WAIT_ACK) && held_req && !REMOTE_INFO_IN.all_ack &&
      !OVERRIDE_IN && !RES_BLOCK_IN
      |=> (APP_GRANT_OUT == GRANT_RESET) && REQ_OTHER_BAYS_OUT;
   endproperty
   a_no_early: assert property (p_no_early)
      else $error("Grant given before acknowledges.");

   // A bay held by the first instance takes no reservation here.
   property p_chain_hold;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      CHAIN_LINK_IN.reserved && !RESERVED_OUT |=> !RESERVED_OUT;
   endproperty
   a_chain_hold: assert property (p_chain_hold)
      else $error("Reservation made while first instance reserved.");

   // The chain output passes on a reservation of the first instance.
   property p_chain_pass;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      CHAIN_LINK_IN.reserved && !RES_BLOCK_IN |=> CHAIN_LINK_OUT.reserved;
   endproperty
   a_chain_pass: assert property (p_chain_pass)
      else $error("Chain output lost the reservation.");

   // An acknowledged remote reservation leaves no own grant or request.
   property p_ack_alone;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      ACK_TO_OTHER_BAY_OUT |-> RESERVED_OUT && !REQ_OTHER_BAYS_OUT &&
         (APP_GRANT_OUT == GRANT_RESET);
   endproperty
   a_ack_alone: assert property (p_ack_alone)
      else $error("Acknowledge given together with an own reservation.");

   // Withdrawn remote request frees the bay at the next edge.
   property p_remote_free;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      ACK_TO_OTHER_BAY_OUT && !remote_req
      |=> !ACK_TO_OTHER_BAY_OUT && !RESERVED_OUT;
   endproperty
   a_remote_free: assert property (p_remote_free)
      else $error("Remote reservation not released.");

   // Main scenarios.
   c_own_grant: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      free_now && any_req ##1 (APP_GRANT_OUT != 0));
   c_ack_path: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      REQ_OTHER_BAYS_OUT && (APP_GRANT_OUT == 0) ##1 (APP_GRANT_OUT != 0));
   c_remote: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      ACK_TO_OTHER_BAY_OUT ##1 !ACK_TO_OTHER_BAY_OUT);
   c_block: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      RESERVED_OUT ##1 RES_BLOCK_IN);

endmodule : bra_arbiter

// >>> verification/bra_far_model.sv
// Far side of the arbiter: switch controllers and remote bay inputs.
module bra_far_model #(
   parameter int TMO = 10
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [bra_pkg::NUM_APP-1:0] app_cmd_in,
   input wire logic remote_cmd_in,
   input wire logic ack_en_in,
   input wire logic [3:0] ack_delay_in,
   input wire logic req_other_in,
   input wire logic [bra_pkg::NUM_APP-1:0] grant_in,
   output logic [bra_pkg::NUM_APP-1:0] app_req_out,
   output bra_pkg::bra_remote_t remote_out,
   output logic cause_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import bra_pkg::*;
   logic [3:0] ack_cnt_reg;
   int tmr_reg;
   logic quit_reg;

   // ==========================================================
   // Outputs
   // ==========================================================
   // Flags travel packed in one word; acknowledges come after a delay.
   always_comb begin
      remote_out.remote_request_flag = remote_cmd_in;
      remote_out.remote_request_valid = remote_cmd_in;
      remote_out.all_ack = ack_en_in && req_other_in &&
         (ack_cnt_reg >= ack_delay_in);
      app_req_out = quit_reg ? '0 : app_cmd_in;
      cause_out = quit_reg;
   end

   // ==========================================================
   // Timers
   // ==========================================================
   // The controller gives up when no grant comes in time.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ack_cnt_reg <= 4'h0;
         tmr_reg <= 0;
         quit_reg <= 1'b0;
      end else begin
         if (!req_other_in) begin
            ack_cnt_reg <= 4'h0;
         end else if (ack_cnt_reg != 4'hF) begin
            ack_cnt_reg <= ack_cnt_reg + 4'h1;
         end
         if (app_cmd_in == '0) begin
            tmr_reg <= 0;
            quit_reg <= 1'b0;
         end else if (grant_in == '0 && !quit_reg) begin
            if (tmr_reg == TMO) begin
               quit_reg <= 1'b1;
            end else begin
               tmr_reg <= tmr_reg + 1;
            end
         end
      end
   end
endmodule : bra_far_model

// >>> verification/testbench.sv
// Self-checking bench for the bay reservation arbiter.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import bra_pkg::*;
   logic clk, rst, blk, ovr, rem_cmd, ack_en, cause;
   logic [7:0] own_only, app_cmd, app_req;
   logic [3:0] ack_dly;
   bra_remote_t remote;
   bra_chain_t chain_in, chain_out;
   logic [7:0] grant;
   logic req_other, ack, reserved;
   int fail_count = 0;
   int checked = 0;

   // ==========================================================
   // Instances
   // ==========================================================
   bra_arbiter u_dut (.REF_CLK_IN(clk), .RST_IN(rst), .APP_REQ_IN(app_req),
      .OWN_BAY_ONLY_IN(own_only), .RES_BLOCK_IN(blk), .OVERRIDE_IN(ovr),
      .REMOTE_INFO_IN(remote), .CHAIN_LINK_IN(chain_in),
      .APP_GRANT_OUT(grant), .REQ_OTHER_BAYS_OUT(req_other),
      .ACK_TO_OTHER_BAY_OUT(ack), .RESERVED_OUT(reserved),
      .CHAIN_LINK_OUT(chain_out));
   bra_far_model #(.TMO(10)) u_far (.clk_in(clk), .rst_in(rst),
      .app_cmd_in(app_cmd), .remote_cmd_in(rem_cmd), .ack_en_in(ack_en),
      .ack_delay_in(ack_dly), .req_other_in(req_other), .grant_in(grant),
      .app_req_out(app_req), .remote_out(remote), .cause_out(cause));

   // ==========================================================
   // Tasks
   // ==========================================================
   // Clock with a 100 ns period.
   always #50 clk = ~clk;

   task automatic chk(input string nm, input logic [11:0] exp,
                      input logic [11:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Lets edges pass, then samples away from the rising edge.
   task automatic look(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : look

   // Compares grant, other-bay request, acknowledge and reserved.
   task automatic expo(input logic [7:0] g, input logic [2:0] f);
      chk("outputs", {1'b0, g, f}, {1'b0, grant, req_other, ack, reserved});
   endtask : expo

   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report

   // Cuts a hang short.
   initial begin
      repeat (3000) @(posedge clk);
      fail_count++;
      final_report;
   end

   // ==========================================================
   // Tests
   // ==========================================================
   initial begin
      clk = 1'b0; rst = 1'b1; blk = 1'b0; ovr = 1'b0; rem_cmd = 1'b0;
      ack_en = 1'b1; ack_dly = 4'h3; own_only = 8'hFF; app_cmd = 8'h00;
      chain_in = '0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      look(1); expo(8'h00, 3'h0);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk); app_cmd <= 8'h01 << i;
         look(1); expo(8'h01 << i, 3'h1);
         @(posedge clk); app_cmd <= 8'h00;
         look(1); expo(8'h00, 3'h0);
      end
      // Simultaneous requesters and a remote request all at once.
      @(posedge clk); app_cmd <= 8'hA4; rem_cmd <= 1'b1;
      look(1); expo(8'h04, 3'h1);
      look(3); expo(8'h04, 3'h1);
      chk("chain", 12'h001, {11'h000, chain_out.reserved});
      @(posedge clk); app_cmd <= 8'h00;
      look(1); expo(8'h00, 3'h0);
      look(1); expo(8'h00, 3'h3);
      @(posedge clk); app_cmd <= 8'h02;
      look(2); expo(8'h00, 3'h3);
      @(posedge clk); app_cmd <= 8'h00; rem_cmd <= 1'b0;
      look(1); expo(8'h00, 3'h0);
      // Reservation of other bays with delayed acknowledges.
      @(posedge clk); own_only <= 8'hFE; app_cmd <= 8'h01;
      look(1); expo(8'h00, 3'h5);
      for (int k = 0; k < 10 && grant !== 8'h01; k++) look(1);
      expo(8'h01, 3'h5);
      @(posedge clk); app_cmd <= 8'h00;
      look(1); expo(8'h00, 3'h0);
      // Acknowledges never come: the controller abandons.
      @(posedge clk); ack_en <= 1'b0; app_cmd <= 8'h01;
      look(16); chk("cause", 12'h001, {11'h000, cause});
      expo(8'h00, 3'h0);
      @(posedge clk); app_cmd <= 8'h00;
      look(1);
      @(posedge clk); ovr <= 1'b1; app_cmd <= 8'h01;
      look(1); chk("grant", 12'h001, {4'h0, grant});
      @(posedge clk); ovr <= 1'b0;
      look(1); expo(8'h01, 3'h1);
      // Block clears everything and refuses both kinds of request.
      @(posedge clk); blk <= 1'b1;
      look(1); expo(8'h00, 3'h0);
      @(posedge clk); rem_cmd <= 1'b1;
      look(2); expo(8'h00, 3'h0);
      @(posedge clk); blk <= 1'b0; app_cmd <= 8'h00;
      look(2); expo(8'h00, 3'h3);
      // A reserved first instance holds off this one.
      @(posedge clk); rem_cmd <= 1'b0; chain_in <= '{reserved: 1'b1};
      app_cmd <= 8'h80;
      look(2); expo(8'h00, 3'h0);
      chk("chain", 12'h001, {11'h000, chain_out.reserved});
      @(posedge clk); chain_in <= '0;
      look(1); expo(8'h80, 3'h1);
      final_report;
   end
endmodule : testbench
